// [ohs_defines.vh]
// constants for the host operating control block
`ifndef OHS_DEFINES_VH
`define OHS_DEFINES_VH
// register byte addresses
`define OHS_ADDR_VERSION   12'h400
`define OHS_ADDR_CONTROL   12'h404
`define OHS_ADDR_IRQ_STAT  12'h408
`define OHS_ADDR_IRQ_MASK  12'h40C
`define OHS_ADDR_STIM      12'h410
// version value, bcd 1.0
`define OHS_VERSION_VAL    8'h10
// control register fields
`define OHS_CTL_WAKE_EN    10
`define OHS_CTL_WAKE_SUP   9
`define OHS_CTL_IRQ_SMI    8
`define OHS_CTL_FS_HI      7
`define OHS_CTL_FS_LO      6
`define OHS_CTL_CTRL_EN    5
`define OHS_CTL_ISO_EN     4
`define OHS_CTL_BULK_EN    3
`define OHS_CTL_MASK       11'h7F8
// status register fields
`define OHS_ST_RESUME      1
`define OHS_ST_SOF         0
`define OHS_ST_WIDTH       2
// stimulus register fields (test hook: software-driven events)
`define OHS_STIM_SWRST     0
`define OHS_STIM_RESUME    1
// functional states
`define OHS_FS_RESET       2'h0
`define OHS_FS_RESUME      2'h1
`define OHS_FS_OPER        2'h2
`define OHS_FS_SUSPEND     2'h3
// timing
`define OHS_CLK_MHZ        100
`define OHS_SOF_DELAY_US   1000
`define OHS_FRAME_US       1000
`define OHS_PORT_RST_US    10
`endif

// [ohs_frame_timer.v]
// frame timer: start-of-frame pacing after entering operational
`timescale 1ns/100ps
`include "ohs_defines.vh"
module ohs_frame_timer #(
  parameter SOF_DELAY = `OHS_SOF_DELAY_US * `OHS_CLK_MHZ,
  parameter FRAME_LEN = `OHS_FRAME_US * `OHS_CLK_MHZ
) (
  input  wire clk,
  input  wire srst,
  input  wire oper,
  output reg  sof_pulse
);
  reg [19:0] cnt_reg;
  reg        run_reg;

  // =====================================================================
  // count delay then frame periods while operational
  always @(posedge clk) begin
    if (srst || !oper) begin
      cnt_reg   <= 20'h00000;
      run_reg   <= 1'b0;
      sof_pulse <= 1'b0;
    end else begin
      sof_pulse <= 1'b0;
      if (!run_reg && cnt_reg == SOF_DELAY[19:0] - 20'h00001) begin
        run_reg   <= 1'b1; // first frame 1 ms after entry
        cnt_reg   <= 20'h00000;
        sof_pulse <= 1'b1;
      end else if (run_reg && cnt_reg == FRAME_LEN[19:0] - 20'h00001) begin
        cnt_reg   <= 20'h00000;
        sof_pulse <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 20'h00001;
      end
    end
  end
endmodule

// [ohs_host_ctrl.v]
// host operating control and version registers with apb slave
`timescale 1ns/100ps
`include "ohs_defines.vh"
module ohs_host_ctrl #(
  parameter SOF_DELAY = `OHS_SOF_DELAY_US * `OHS_CLK_MHZ,
  parameter FRAME_LEN = `OHS_FRAME_US * `OHS_CLK_MHZ,
  parameter PORT_RST  = `OHS_PORT_RST_US * `OHS_CLK_MHZ
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        port_resume,
  input  wire        iso_ed_seen,
  output reg         iso_proceed,
  output reg         bulk_allowed,
  output reg         ctrl_allowed,
  output reg         sof_strobe,
  output reg         port_reset,
  output reg         hub_reset,
  output reg         wake_signal,
  output reg         irq_host,
  output reg         irq_smi
);
  reg                   wake_signal_enable_reg;
  reg                   wake_supported_flag_reg;
  reg                   irq_to_sys_mgmt_reg;
  reg [1:0]             controller_func_state_reg;
  reg [1:0]             controller_func_state_next;
  reg                   bulk_queue_enable_reg;
  reg                   ctrl_queue_enable_reg;
  reg                   iso_queue_enable_reg;
  reg [`OHS_ST_WIDTH-1:0] event_status_reg;
  reg [`OHS_ST_WIDTH-1:0] irq_mask_reg;
  reg                   resume_in_reg;
  reg [15:0]            port_rst_cnt_reg;
  reg                   sw_rst_reg;
  wire                  sof_pulse;
  wire                  wr_en;
  wire                  rd_en;
  wire                  resume_edge;
  wire                  irq_any;
  wire [10:0]           ctl_word;

  // =====================================================================
  // address decode helper
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OHS_ADDR_VERSION) || (a == `OHS_ADDR_CONTROL) ||
               (a == `OHS_ADDR_IRQ_STAT) || (a == `OHS_ADDR_IRQ_MASK) ||
               (a == `OHS_ADDR_STIM);
    end
  endfunction

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  // rising edge of downstream resume signalling
  assign resume_edge = port_resume && !resume_in_reg;
  // events leave regardless of wake enable
  assign irq_any = |(event_status_reg & irq_mask_reg);
  assign ctl_word = {wake_signal_enable_reg, wake_supported_flag_reg,
                     irq_to_sys_mgmt_reg, controller_func_state_reg,
                     ctrl_queue_enable_reg, iso_queue_enable_reg,
                     bulk_queue_enable_reg, 3'h0};

  // =====================================================================
  // frame timer
  ohs_frame_timer #(
    .SOF_DELAY (SOF_DELAY),
    .FRAME_LEN (FRAME_LEN)
  ) u_timer (
    .clk       (clk),
    .srst      (srst | sw_rst_reg),
    .oper      (controller_func_state_reg == `OHS_FS_OPER),
    .sof_pulse (sof_pulse)
  );

  // =====================================================================
  // functional state next value
  always @* begin
    controller_func_state_next = controller_func_state_reg;
    case (controller_func_state_reg)
      `OHS_FS_SUSPEND: begin
        if (resume_edge)
          controller_func_state_next = `OHS_FS_RESUME;
      end
      default: controller_func_state_next = controller_func_state_reg;
    endcase
    if (wr_en && paddr == `OHS_ADDR_CONTROL)
      controller_func_state_next = pwdata[`OHS_CTL_FS_HI:`OHS_CTL_FS_LO];
  end

  // =====================================================================
  // control register, hardware and software reset
  always @(posedge clk) begin
    if (srst) begin
      wake_signal_enable_reg    <= 1'b0;
      wake_supported_flag_reg   <= 1'b0;
      irq_to_sys_mgmt_reg       <= 1'b0;
      controller_func_state_reg <= `OHS_FS_RESET;
      bulk_queue_enable_reg     <= 1'b0;
      ctrl_queue_enable_reg     <= 1'b0;
      iso_queue_enable_reg      <= 1'b0;
      sw_rst_reg                <= 1'b0;
    end else if (sw_rst_reg) begin
      // software reset keeps wake supported and routing
      wake_signal_enable_reg    <= 1'b0;
      controller_func_state_reg <= `OHS_FS_SUSPEND;
      bulk_queue_enable_reg     <= 1'b0;
      ctrl_queue_enable_reg     <= 1'b0;
      iso_queue_enable_reg      <= 1'b0;
      sw_rst_reg                <= 1'b0;
    end else begin
      controller_func_state_reg <= controller_func_state_next;
      if (wr_en && paddr == `OHS_ADDR_STIM)
        sw_rst_reg <= pwdata[`OHS_STIM_SWRST];
      if (wr_en && paddr == `OHS_ADDR_CONTROL) begin
        wake_signal_enable_reg  <= pwdata[`OHS_CTL_WAKE_EN];
        wake_supported_flag_reg <= pwdata[`OHS_CTL_WAKE_SUP];
        irq_to_sys_mgmt_reg     <= pwdata[`OHS_CTL_IRQ_SMI];
        ctrl_queue_enable_reg   <= pwdata[`OHS_CTL_CTRL_EN];
        iso_queue_enable_reg    <= pwdata[`OHS_CTL_ISO_EN];
        bulk_queue_enable_reg   <= pwdata[`OHS_CTL_BULK_EN];
      end
    end
  end

  // =====================================================================
  // event status, mask; set wins over write-one clear
  always @(posedge clk) begin
    if (srst || sw_rst_reg) begin
      event_status_reg <= {`OHS_ST_WIDTH{1'b0}};
      resume_in_reg    <= 1'b0;
    end else begin
      resume_in_reg <= port_resume;
      if (wr_en && paddr == `OHS_ADDR_IRQ_STAT)
        event_status_reg <= (event_status_reg &
                             ~pwdata[`OHS_ST_WIDTH-1:0]) |
                            {resume_edge && controller_func_state_reg ==
                             `OHS_FS_SUSPEND, sof_pulse};
      else
        event_status_reg <= event_status_reg |
                            {resume_edge && controller_func_state_reg ==
                             `OHS_FS_SUSPEND, sof_pulse};
    end
  end

  always @(posedge clk) begin
    if (srst || sw_rst_reg)
      irq_mask_reg <= {`OHS_ST_WIDTH{1'b0}};
    else if (wr_en && paddr == `OHS_ADDR_IRQ_MASK)
      irq_mask_reg <= pwdata[`OHS_ST_WIDTH-1:0];
  end

  // =====================================================================
  // link-side outputs, all registered
  always @(posedge clk) begin
    if (srst) begin
      port_rst_cnt_reg <= PORT_RST[15:0];
      port_reset       <= 1'b1;
      hub_reset        <= 1'b1;
      bulk_allowed     <= 1'b0;
      ctrl_allowed     <= 1'b0;
      iso_proceed      <= 1'b0;
      sof_strobe       <= 1'b0;
      wake_signal      <= 1'b0;
      irq_host         <= 1'b0;
      irq_smi          <= 1'b0;
    end else begin
      hub_reset <= 1'b0;
      if (port_rst_cnt_reg != 16'h0000) begin
        port_rst_cnt_reg <= port_rst_cnt_reg - 16'h0001;
        port_reset       <= 1'b1;
      end else begin
        port_reset <= 1'b0;
      end
      sof_strobe <= sof_pulse;
      // bulk and control list enables take effect only at a frame boundary
      if (sof_pulse) begin
        bulk_allowed <= bulk_queue_enable_reg;
        ctrl_allowed <= ctrl_queue_enable_reg;
      end
      if (controller_func_state_reg != `OHS_FS_OPER) begin
        bulk_allowed <= 1'b0;
        ctrl_allowed <= 1'b0;
      end
      iso_proceed <= iso_ed_seen && iso_queue_enable_reg;
      wake_signal <= wake_signal_enable_reg &&
                     event_status_reg[`OHS_ST_RESUME];
      irq_host <= irq_any && !irq_to_sys_mgmt_reg;
      irq_smi  <= irq_any && irq_to_sys_mgmt_reg;
    end
  end

  // =====================================================================
  // apb slave: no wait states, read data in access phase
  always @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (rd_en) begin
        case (paddr)
          // fixed bcd version
          `OHS_ADDR_VERSION:  prdata <= {24'h000000, `OHS_VERSION_VAL};
          `OHS_ADDR_CONTROL:  prdata <= {21'h000000, ctl_word};
          `OHS_ADDR_IRQ_STAT: prdata <= {30'h00000000, event_status_reg};
          `OHS_ADDR_IRQ_MASK: prdata <= {30'h00000000, irq_mask_reg};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// [ohs_host_ctrl_props.sv]
// assertion checker for the host operating control block
`timescale 1ns/100ps
module ohs_host_ctrl_props #(
  parameter SOF_DELAY = 20,
  parameter FRAME_LEN = 30,
  parameter PORT_RST  = 5
) (
  input logic        clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        port_resume,
  input logic        iso_ed_seen,
  input logic        iso_proceed,
  input logic        bulk_allowed,
  input logic        ctrl_allowed,
  input logic        sof_strobe,
  input logic        port_reset,
  input logic        hub_reset,
  input logic        wake_signal,
  input logic        irq_host,
  input logic        irq_smi
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========
  // reset release steps
  sequence s_rel;
    hub_reset && port_reset ##1 !hub_reset;
  endsequence
  a_hub_release: assert property ($fell(srst) |-> s_rel)
    else $error("hub reset release wrong");
  a_port_release: assert property ($fell(srst) |-> ##[4:8] !port_reset)
    else $error("port reset length wrong");
  // ==========
  // register reads
  a_version_read: assert property (pready && !pwrite && paddr == 12'h400
    |-> prdata == 32'h10)
    else $error("version read wrong");
  a_rsvd_zero: assert property (pready && !pwrite && paddr == 12'h404
    |-> prdata[31:11] == 21'h0)
    else $error("reserved control bits set");
  a_err_answer: assert property (pslverr
    |-> pready && (pwrite || prdata == 32'h0))
    else $error("error answer malformed");
  // ==========
  // events and lists
  a_route_excl: assert property (!(irq_host && irq_smi))
    else $error("both interrupt routes high");
  a_sof_gap: assert property (sof_strobe |=> !sof_strobe [*8])
    else $error("frame starts too close");
  a_iso_cause: assert property (iso_proceed |-> $past(iso_ed_seen))
    else $error("iso proceed without descriptor");
  a_bulk_frame: assert property ($rose(bulk_allowed)
    |-> sof_strobe || $past(sof_strobe))
    else $error("bulk allowed off frame start");
  a_ctrl_frame: assert property ($rose(ctrl_allowed)
    |-> sof_strobe || $past(sof_strobe))
    else $error("control allowed off frame start");
endmodule
bind ohs_host_ctrl ohs_host_ctrl_props #(.SOF_DELAY(SOF_DELAY),
  .FRAME_LEN(FRAME_LEN), .PORT_RST(PORT_RST)) i_ohs_host_ctrl_props (.*);

// [ohs_port_model.sv]
// downstream port model: resume signalling and iso descriptor walker
`timescale 1ns/100ps
module ohs_port_model (
  input  logic clk,
  input  logic res_req,
  input  logic iso_req,
  output logic port_resume,
  output logic iso_ed_seen
);
  // resume held as a level while requested
  always @(posedge clk)
    port_resume <= res_req;
  // walker meets an iso descriptor on request
  assign iso_ed_seen = iso_req;
endmodule

// [tb_ohs_host_ctrl.sv]
// self-checking bench for the host operating control block
`timescale 1ns/100ps
`include "ohs_defines.vh"
module tb_ohs_host_ctrl;
  logic        clk, srst, psel, penable, pwrite, res_req, iso_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pready, pslverr, port_resume, iso_ed_seen, iso_proceed;
  logic        bulk_allowed, ctrl_allowed, sof_strobe, port_reset;
  logic        hub_reset, wake_signal, irq_host, irq_smi;
  logic [32:0] expq[$];
  int          error_cnt = 0, cmp_count = 0, n;
  ohs_host_ctrl #(.SOF_DELAY(20), .FRAME_LEN(30), .PORT_RST(5))
    i_ohs_host_ctrl (.*);
  ohs_port_model i_ohs_port_model (.*);
  // ==========
  // clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ==========
  // checking and closing
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // read results taken off the queue as they appear
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  // ==========
  // bus and wait tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) error_cnt++;
    if (pready !== 1'b1) end_sim;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task automatic see(input logic [32:0] e);
    @(negedge clk);
    chk({wake_signal, irq_host, irq_smi, bulk_allowed, ctrl_allowed,
         iso_proceed}, e);
    @(posedge clk);
  endtask
  task automatic wait_sof;
    for (n = 0; n < 60 && sof_strobe !== 1'b1; n++) @(negedge clk);
    if (n == 60) error_cnt++;
    if (n == 60) end_sim;
  endtask
  // ==========
  // main sequence
  initial begin
    {psel, penable, pwrite, res_req, iso_req, paddr, pwdata} = 0;
    srst = 1;
    rnd = $urandom(22);
    repeat (6) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(`OHS_ADDR_VERSION, 33'h10);
    rd(`OHS_ADDR_CONTROL, 33'h0);
    rd(12'h414, 33'h100000000);
    apb(1, `OHS_ADDR_CONTROL, 32'hFFFFFFFF);
    rd(`OHS_ADDR_CONTROL, 33'h7F8);
    apb(1, `OHS_ADDR_IRQ_MASK, rnd);
    rd(`OHS_ADDR_IRQ_MASK, {31'h0, rnd[1:0]});
    apb(1, `OHS_ADDR_STIM, 32'h1);
    rd(`OHS_ADDR_CONTROL, 33'h3C0);
    $display("test registers done");
    res_req <= 1;
    repeat (3) @(posedge clk);
    rd(`OHS_ADDR_CONTROL, 33'h340);
    rd(`OHS_ADDR_IRQ_STAT, 33'h2);
    apb(1, `OHS_ADDR_IRQ_MASK, 32'h2);
    apb(1, `OHS_ADDR_CONTROL, 32'h740);
    see(6'b101000);
    apb(1, `OHS_ADDR_CONTROL, 32'h240);
    see(6'b010000);
    apb(1, `OHS_ADDR_IRQ_STAT, 32'h2);
    see(6'b000000);
    res_req <= 0;
    $display("test resume and interrupts done");
    apb(1, `OHS_ADDR_CONTROL, 32'h2B8);
    wait_sof;
    chk(n > 12 && n < 24, 1'b1);
    @(posedge clk);
    iso_req <= 1;
    @(posedge clk);
    iso_req <= 0;
    see(6'b000111);
    apb(1, `OHS_ADDR_CONTROL, 32'h280);
    see(6'b000110);
    wait_sof;
    @(posedge clk);
    see(6'b000000);
    $display("test frames done");
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(`OHS_ADDR_CONTROL, 33'h0);
    $display("test hardware reset done");
    end_sim;
  end
endmodule
